//--- hdl/cso_consts.vh
// Constants for the subtract, trap, sign-extend and mask-load unit
`ifndef CSO_CONSTS_VH
`define CSO_CONSTS_VH
// Opcodes
`define CSO_OP_SUB_IMM 16'h3730
`define CSO_OP_SUB_IX 16'h3740
`define CSO_OP_SUB_IZ 16'h3760
`define CSO_OP_SUB_EXT 16'h3770
`define CSO_OP_TRAP 16'h3720
`define CSO_OP_SIGN_EXT 16'h27F8
`define CSO_OP_MSK 16'h372F
// Cycle counts
`define CSO_CYC_SUB_IMM 5'h04
`define CSO_CYC_SUB_MEM 5'h06
`define CSO_CNT_STEP 5'h01
`define CSO_CYC_TRAP 5'h10
`define CSO_CYC_SHORT 5'h02
// Other constants
`define CSO_PC_STEP 20'h00002
`define CSO_BYTE_ONES 8'hFF
`define CSO_BYTE_ZERO 8'h00
`define CSO_SIGN_BIT 7
// Flag positions in the 4-bit N Z V C group
`define CSO_F_N 3
`define CSO_F_Z 2
`define CSO_F_V 1
`define CSO_F_C 0
`endif

//--- hdl/cso_alu.v
// Combinational word subtractor with N Z V C flags
`timescale 1ns/100ps
module cso_alu (
    input wire [15:0] a_in,
    input wire [15:0] b_in,
    output wire [15:0] diff_out,
    output wire [3:0] flags_out
);
`include "cso_consts.vh"
    wire [16:0] full;
    // Borrow comes out as bit 16 of the extended difference
    assign full = {1'b0, a_in} - {1'b0, b_in};
    assign diff_out = full[15:0];
    assign flags_out[`CSO_F_N] = full[15];
    assign flags_out[`CSO_F_Z] = (full[15:0] == 16'h0000);
    // Overflow when operand signs differ and result sign flips
    assign flags_out[`CSO_F_V] = (a_in[15] ^ b_in[15]) & (a_in[15] ^ full[15]);
    assign flags_out[`CSO_F_C] = full[16];
endmodule

//--- hdl/cso_exec.v
// Execution unit: word subtract into E, trap entry, sign extend, masks
// What this block does
// - Subtract word operand from E into E, set N Z V C; immediate four cycles
// - Trap adds two to bank extension and counter, sixteen cycles
// - A gets all ones if B bit 7 set else zeros; N Z; two cycles
// - D high byte to X mask, low byte to Y mask; flags kept; two cycles
`timescale 1ns/100ps
module cso_exec (
    input wire clk_in,
    input wire reset_in,
    input wire start_in,
    input wire [15:0] opcode_in,
    input wire [15:0] operand_in,
    input wire [15:0] acc_e_in,
    input wire [15:0] acc_d_in,
    input wire [19:0] bank_ext_pc_in,
    input wire [3:0] flags_in,
    output wire busy_out,
    output reg done_out,
    output reg illegal_out,
    output reg [15:0] acc_e_out,
    output reg acc_e_we_out,
    output reg [7:0] acc_a_out,
    output reg acc_a_we_out,
    output reg [7:0] x_index_mask_out,
    output reg [7:0] y_index_mask_out,
    output reg masks_we_out,
    output reg [19:0] bank_ext_pc_out,
    output reg bank_ext_pc_we_out,
    output reg exception_out,
    output reg [3:0] flags_out
);
`include "cso_consts.vh"

    ////////////////////////////////////////////////////////////////////
    // Two states suffice: the counter carries the instruction length
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    // Snapshot of the instruction and its operands, taken at start
    reg state_q, state_d;
    reg [4:0] cnt_q, cnt_d;
    reg [15:0] op_q, op_d;
    reg [15:0] arg_q, arg_d;
    reg [15:0] e_q, e_d;
    reg [15:0] dd_q, dd_d;
    reg [19:0] pc_q, pc_d;
    reg [3:0] fl_q, fl_d;
    // Subtractor results, sign-extend byte and end-of-budget marker
    wire [15:0] diff;
    wire [3:0] sub_flags;
    wire [7:0] b_byte;
    wire [7:0] ext_byte;
    wire last_cycle;

    // Decode shared by start length and result paths
    function is_sub_word;
        input [15:0] op;
        begin
            is_sub_word = (op == `CSO_OP_SUB_IMM) ||
                (op == `CSO_OP_SUB_IX) ||
                (op == `CSO_OP_SUB_IZ) || (op == `CSO_OP_SUB_EXT);
        end
    endfunction

    // Cycle budget per opcode; the memory forms share one length
    function [4:0] cycles_of;
        input [15:0] op;
        begin
            if (op == `CSO_OP_SUB_IMM) begin
                cycles_of = `CSO_CYC_SUB_IMM;
            end else if (is_sub_word(op)) begin
                cycles_of = `CSO_CYC_SUB_MEM;
            end else if (op == `CSO_OP_TRAP) begin
                cycles_of = `CSO_CYC_TRAP;
            end else begin
                cycles_of = `CSO_CYC_SHORT;
            end
        end
    endfunction

    // Opcodes this unit runs; anything else is refused at start
    function known;
        input [15:0] op;
        begin
            known = is_sub_word(op) || (op == `CSO_OP_TRAP) ||
                (op == `CSO_OP_SIGN_EXT) || (op == `CSO_OP_MSK);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Operands are captured at start, so the core may move on meanwhile
    cso_alu cso_alu_inst (
        .a_in(e_q),
        .b_in(arg_q),
        .diff_out(diff),
        .flags_out(sub_flags)
    );

    // B is the low byte of D; only its top bit matters here
    assign b_byte = dd_q[7:0];
    assign ext_byte = b_byte[`CSO_SIGN_BIT] ? `CSO_BYTE_ONES :
        `CSO_BYTE_ZERO;
    assign busy_out = (state_q == ST_RUN);
    // Last counted cycle; shared by the sequencer and the result stage
    assign last_cycle = (state_q == ST_RUN) && (cnt_q == `CSO_CNT_STEP);

    ////////////////////////////////////////////////////////////////////
    // Sequencer: counts down the instruction's cycle budget
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        op_d = op_q;
        arg_d = arg_q;
        e_d = e_q;
        dd_d = dd_q;
        pc_d = pc_q;
        fl_d = fl_q;
        case (state_q)
            ST_IDLE: begin
                if (start_in && known(opcode_in)) begin
                    state_d = ST_RUN;
                    cnt_d = cycles_of(opcode_in) - `CSO_CNT_STEP;
                    op_d = opcode_in;
                    arg_d = operand_in;
                    e_d = acc_e_in;
                    dd_d = acc_d_in;
                    pc_d = bank_ext_pc_in;
                    fl_d = flags_in;
                end
            end
            ST_RUN: begin
                // Idle again on the edge that finishes the budget
                cnt_d = cnt_q - `CSO_CNT_STEP;
                if (last_cycle) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Reset clears the whole instruction context
    always @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            op_q <= 16'h0000;
            arg_q <= 16'h0000;
            e_q <= 16'h0000;
            dd_q <= 16'h0000;
            pc_q <= 20'h00000;
            fl_q <= 4'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            op_q <= op_d;
            arg_q <= arg_d;
            e_q <= e_d;
            dd_q <= dd_d;
            pc_q <= pc_d;
            fl_q <= fl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Results registered on the last cycle; strobes last one cycle
    always @(posedge clk_in) begin
        if (reset_in) begin
            done_out <= 1'b0;
            illegal_out <= 1'b0;
            acc_e_out <= 16'h0000;
            acc_e_we_out <= 1'b0;
            acc_a_out <= 8'h00;
            acc_a_we_out <= 1'b0;
            x_index_mask_out <= 8'h00;
            y_index_mask_out <= 8'h00;
            masks_we_out <= 1'b0;
            bank_ext_pc_out <= 20'h00000;
            bank_ext_pc_we_out <= 1'b0;
            exception_out <= 1'b0;
            flags_out <= 4'h0;
        end else begin
            // Strobes default low so each stands for exactly one cycle
            done_out <= 1'b0;
            acc_e_we_out <= 1'b0;
            acc_a_we_out <= 1'b0;
            masks_we_out <= 1'b0;
            bank_ext_pc_we_out <= 1'b0;
            exception_out <= 1'b0;
            // Unknown opcodes are flagged, not executed
            illegal_out <= (state_q == ST_IDLE) && start_in &&
                !known(opcode_in);
            // Commit the captured instruction on its last cycle
            if (last_cycle) begin
                done_out <= 1'b1;
                flags_out <= fl_q;
                if (is_sub_word(op_q)) begin
                    acc_e_out <= diff;
                    acc_e_we_out <= 1'b1;
                    flags_out <= sub_flags;
                end else if (op_q == `CSO_OP_TRAP) begin
                    bank_ext_pc_out <= pc_q + `CSO_PC_STEP;
                    bank_ext_pc_we_out <= 1'b1;
                    exception_out <= 1'b1;
                end else if (op_q == `CSO_OP_SIGN_EXT) begin
                    acc_a_out <= ext_byte;
                    acc_a_we_out <= 1'b1;
                    flags_out[`CSO_F_N] <= ext_byte[`CSO_SIGN_BIT];
                    flags_out[`CSO_F_Z] <= (ext_byte == `CSO_BYTE_ZERO);
                end else begin
                    x_index_mask_out <= dd_q[15:8];
                    y_index_mask_out <= dd_q[7:0];
                    masks_we_out <= 1'b1;
                end
            end
        end
    end
endmodule

//--- sim/cso_exec_properties.sv
// Port-level checker for the execution unit
`timescale 1ns/100ps
module cso_exec_properties (
    input wire clk_in,
    input wire reset_in,
    input wire start_in,
    input wire [15:0] opcode_in,
    input wire [15:0] operand_in,
    input wire [15:0] acc_e_in,
    input wire [15:0] acc_d_in,
    input wire [19:0] bank_ext_pc_in,
    input wire [3:0] flags_in,
    input wire busy_out,
    input wire done_out,
    input wire [15:0] acc_e_out,
    input wire acc_e_we_out,
    input wire [7:0] acc_a_out,
    input wire acc_a_we_out,
    input wire [7:0] x_index_mask_out,
    input wire [7:0] y_index_mask_out,
    input wire masks_we_out,
    input wire [19:0] bank_ext_pc_out,
    input wire exception_out,
    input wire [3:0] flags_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (reset_in);
// Only an idle start is taken
wire take = start_in && !busy_out;
property p_sub;
    take && opcode_in == 16'h3730 |-> ##4 done_out && acc_e_we_out
        && acc_e_out == $past(acc_e_in, 4) - $past(operand_in, 4);
endproperty
a_sub: assert property (p_sub) else $error("bad difference");
property p_trap;
    take && opcode_in == 16'h3720 |-> ##16 exception_out
        && bank_ext_pc_out == $past(bank_ext_pc_in, 16) + 20'h00002;
endproperty
a_trap: assert property (p_trap) else $error("bad trap");
property p_sign_ext;
    take && opcode_in == 16'h27F8 |-> ##2 acc_a_we_out
        && acc_a_out == {8{$past(acc_d_in[7], 2)}};
endproperty
a_sign_ext: assert property (p_sign_ext) else $error("bad extend");
property p_nz;
    acc_a_we_out |-> flags_out[3] == acc_a_out[7]
        && flags_out[2] == (acc_a_out == 8'h00);
endproperty
a_nz: assert property (p_nz) else $error("bad N Z");
property p_msk;
    take && opcode_in == 16'h372F |-> ##2 masks_we_out
        && {x_index_mask_out, y_index_mask_out} == $past(acc_d_in, 2);
endproperty
a_msk: assert property (p_msk) else $error("bad masks");
property p_keep;
    take && (opcode_in == 16'h372F || opcode_in == 16'h27F8)
        |-> ##2 flags_out[1:0] == $past(flags_in[1:0], 2);
endproperty
a_keep: assert property (p_keep) else $error("V C changed");
// Immediate subtract must not finish before its fourth cycle
property p_sub_len;
    take && opcode_in == 16'h3730 |-> ##1 (!done_out) [*3];
endproperty
a_sub_len: assert property (p_sub_len) else $error("early end");
// Memory forms of the subtract
property p_sub_mem;
    take && (opcode_in == 16'h3740 || opcode_in == 16'h3760
        || opcode_in == 16'h3770) |-> ##6 done_out && acc_e_we_out
        && acc_e_out == $past(acc_e_in, 6) - $past(operand_in, 6);
endproperty
a_sub_mem: assert property (p_sub_mem) else $error("bad mem sub");
// Mask load leaves every flag as it was
property p_msk_keep;
    take && opcode_in == 16'h372F |-> ##2 flags_out == $past(flags_in, 2);
endproperty
a_msk_keep: assert property (p_msk_keep) else $error("mask flags");
// Trap touches no flag
property p_trap_keep;
    take && opcode_in == 16'h3720 |-> ##16 flags_out == $past(flags_in, 16);
endproperty
a_trap_keep: assert property (p_trap_keep) else $error("trap flags");
endmodule
bind cso_exec cso_exec_properties cso_exec_properties_inst (.*);

//--- sim/tb_cso_exec.sv
// Self-checking bench for the execution unit
`timescale 1ns/100ps
module tb_cso_exec;
reg clk_in = 0;
reg reset_in = 1;
reg start_in = 0;
reg [15:0] opcode_in = 0, operand_in = 0, acc_e_in = 0, acc_d_in = 0;
reg [19:0] bank_ext_pc_in = 0;
reg [3:0] flags_in = 0;
wire busy_out, done_out, illegal_out, acc_e_we_out, acc_a_we_out;
wire masks_we_out, bank_ext_pc_we_out, exception_out;
wire [15:0] acc_e_out;
wire [7:0] acc_a_out, x_index_mask_out, y_index_mask_out;
wire [19:0] bank_ext_pc_out;
wire [3:0] flags_out;
integer err_count = 0;
integer comparisons = 0;
cso_exec cso_exec_inst (.*);
// 200 MHz clock
always #2.5 clk_in = ~clk_in;
////////////////////////////////////////////////////////////////////////
task complete_run;
    begin
        $display("errors %0d checks %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
endtask
task ck(input [19:0] got, input [19:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    end
endtask
// Issue one instruction, count cycles to done; bounded so a hang ends
task exec(input [15:0] op, input [15:0] m, input [15:0] e,
          input [15:0] d, input [3:0] f, input [4:0] n);
    integer k;
    begin
        opcode_in = op;
        operand_in = m;
        acc_e_in = e;
        acc_d_in = d;
        flags_in = f;
        start_in = 1;
        @(negedge clk_in);
        start_in = 0;
        ck(busy_out, 1'h1);
        k = 1;
        while (done_out !== 1'b1 && k < 40) begin
            @(negedge clk_in);
            k = k + 1;
        end
        ck(k, n);
        ck(busy_out, 1'h0);
        ck(illegal_out, 1'h0);
        if (k == 40)
            complete_run;
    end
endtask
////////////////////////////////////////////////////////////////////////
// Borrow out of zero, then signed overflow, issued back to back
task t_sub;
    begin
        exec(16'h3730, 16'h1235, 16'h1234, 16'h0000, 4'h0, 5'h04);
        ck(acc_e_we_out, 1'b1);
        ck(acc_e_out, 16'hFFFF);
        ck(flags_out, 4'h9);
        exec(16'h3770, 16'h0001, 16'h8000, 16'h0000, 4'hF, 5'h06);
        ck(acc_e_out, 16'h7FFF);
        ck(flags_out, 4'h2);
        exec(16'h3740, 16'h0001, 16'h0001, 16'h0000, 4'h0, 5'h06);
        ck(acc_e_out, 16'h0000);
        ck(flags_out, 4'h4);
        exec(16'h3760, 16'h8000, 16'h0000, 16'h0000, 4'h0, 5'h06);
        ck(acc_e_out, 16'h8000);
        ck(flags_out, 4'hB);
    end
endtask
// Counter wraps across the 20-bit top
task t_trap;
    begin
        bank_ext_pc_in = 20'hFFFFF;
        exec(16'h3720, 16'h0000, 16'h0000, 16'h0000, 4'h5, 5'h10);
        ck(exception_out, 1'b1);
        ck(bank_ext_pc_we_out, 1'b1);
        ck(bank_ext_pc_out, 20'h00001);
        ck(flags_out, 4'h5);
    end
endtask
// Both signs of B, junk in the upper byte of D
task t_sign_ext;
    begin
        exec(16'h27F8, 16'h0000, 16'h0000, 16'h1280, 4'h3, 5'h02);
        ck(acc_a_we_out, 1'b1);
        ck(acc_a_out, 8'hFF);
        ck(flags_out, 4'hB);
        exec(16'h27F8, 16'h0000, 16'h0000, 16'hFF7F, 4'h8, 5'h02);
        ck(acc_a_out, 8'h00);
        ck(flags_out, 4'h4);
    end
endtask
task t_msk;
    begin
        exec(16'h372F, 16'h0000, 16'h0000, 16'hA55A, 4'hA, 5'h02);
        ck(masks_we_out, 1'b1);
        ck({x_index_mask_out, y_index_mask_out}, 16'hA55A);
        ck(flags_out, 4'hA);
    end
endtask
// Unknown opcode flagged one cycle; a start while busy is ignored
task t_refuse;
    integer k;
    begin
        opcode_in = 16'h1234;
        start_in = 1'h1;
        @(negedge clk_in);
        start_in = 1'h0;
        ck(illegal_out, 1'h1);
        ck(busy_out, 1'h0);
        ck(done_out, 1'h0);
        ck(flags_out, 4'hA);
        @(negedge clk_in);
        ck(illegal_out, 1'h0);
        opcode_in = 16'h3720;
        flags_in = 4'h6;
        acc_d_in = 16'h0080;
        start_in = 1'h1;
        @(negedge clk_in);
        // Sign extend offered while the trap runs must be dropped
        opcode_in = 16'h27F8;
        ck(busy_out, 1'h1);
        @(negedge clk_in);
        start_in = 1'h0;
        ck(illegal_out, 1'h0);
        k = 2;
        while (done_out !== 1'b1 && k < 40) begin
            ck(acc_a_we_out, 1'h0);
            @(negedge clk_in);
            k = k + 1;
        end
        ck(k, 20'h00010);
        ck(exception_out, 1'h1);
        ck(flags_out, 4'h6);
        @(negedge clk_in);
        ck(acc_a_we_out, 1'h0);
        ck(acc_a_out, 8'h00);
        ck(busy_out, 1'h0);
        if (k == 40)
            complete_run;
    end
endtask
// Reset in mid-instruction clears outputs; next start runs cleanly
task t_reset;
    begin
        opcode_in = 16'h3730;
        operand_in = 16'h0001;
        acc_e_in = 16'h0003;
        start_in = 1'h1;
        @(negedge clk_in);
        start_in = 1'h0;
        reset_in = 1'h1;
        repeat (2) @(negedge clk_in);
        reset_in = 1'h0;
        ck(busy_out, 1'h0);
        ck(acc_e_out, 16'h0000);
        ck(flags_out, 4'h0);
        ck({x_index_mask_out, y_index_mask_out}, 16'h0000);
        ck(bank_ext_pc_out, 20'h00000);
        exec(16'h3730, 16'h0003, 16'h0001, 16'h0000, 4'h0, 5'h04);
        ck(acc_e_out, 16'hFFFE);
        ck(flags_out, 4'h9);
    end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (10) @(negedge clk_in);
    reset_in = 0;
    t_sub;
    t_trap;
    t_sign_ext;
    t_msk;
    t_refuse;
    t_reset;
    complete_run;
end
endmodule
